// ### verilog/ctsu_pkg.sv
// Constants, types and register map of the condition test and skip unit.
// ============================================================================
package ctsu_pkg;

  // ==========================================================================
  // Register map, byte addresses on the register bus.
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_LONG = 8'h08;
  localparam logic [7:0] OFF_FAC = 8'h0c;
  localparam logic [7:0] OFF_GREG = 8'h10;
  localparam logic [7:0] OFF_HALF = 8'h14;
  localparam logic [7:0] OFF_MEM = 8'h18;
  localparam logic [7:0] OFF_INDEX = 8'h1c;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  localparam logic [7:0] OFF_PC = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;

  // ==========================================================================
  // Field positions.
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_MCHK = 1;
  localparam int unsigned FLAG_CCNEG = 2;
  localparam int unsigned FLAG_CCZERO = 3;
  localparam int unsigned ST_SKIP = 0;
  localparam int unsigned ST_FAULT = 1;
  localparam int unsigned ST_CNT = 2;
  localparam int unsigned CMD_W = 15;

  // ==========================================================================
  // Reset values and step sizes.
  localparam logic [31:0] RST_W32 = 32'h0000_0000;
  localparam logic [15:0] RST_W16 = 16'h0000;
  localparam logic [3:0] RST_W4 = 4'h0;
  localparam logic [15:0] ONE_W16 = 16'h0001;
  localparam logic [15:0] TWO_W16 = 16'h0002;

  // ==========================================================================
  // Enumerations.
  typedef enum logic [1:0] {MODE_S, MODE_R, MODE_V, MODE_I} ctsu_mode_t;
  typedef enum logic [2:0] {REL_EQ, REL_GE, REL_GT, REL_LE, REL_LT, REL_NE} ctsu_rel_t;
  typedef enum logic [4:0] {
    OP_LOAD_REG, OP_LOAD_CC, OP_LOAD_FAC, OP_LOAD_HALF, OP_LOAD_LONG,
    OP_LOAD_TRUE, OP_LOAD_FALSE, OP_CMP_MEM, OP_CMP_ZERO, OP_CMP_LONG,
    OP_DEC_INDEX, OP_INC_MEM, OP_INC_INDEX, OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET,
    OP_SKIP_SIGN, OP_SKIP_LOW0, OP_SKIP_MC_CLR, OP_SKIP_MC_SET,
    OP_SKIP_C_CLR, OP_SKIP_C_SET, OP_FSKIP
  } ctsu_op_t;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic len2;
    ctsu_mode_t mode;
    logic [3:0] bitSel;
    ctsu_rel_t rel;
    ctsu_op_t op;
  } ctsu_cmd_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ctsu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctsu_apb_rsp_t;

endpackage : ctsu_pkg

// ### verilog/condition_test_skip_unit.sv
// Condition test, logic-test load and skip unit behind an APB register slave.
`timescale 1ns/1ps
module condition_test_skip_unit (
  input wire logic clk,
  input wire logic srst,
  input wire ctsu_pkg::ctsu_apb_req_t apbReq,
  output ctsu_pkg::ctsu_apb_rsp_t apbRsp
);
  import ctsu_pkg::*;

  // ==========================================================================
  // Helpers.

  // True when the value's sign and zero flags satisfy the relation.
  function automatic logic relTest(input ctsu_rel_t rel, input logic neg, input logic zero);
    case (rel)
      REL_EQ: relTest = zero;
      REL_GE: relTest = !neg;
      REL_GT: relTest = !neg && !zero;
      REL_LE: relTest = neg || zero;
      REL_LT: relTest = neg;
      REL_NE: relTest = !zero;
      default: relTest = 1'b0;
    endcase
  endfunction : relTest

  // Three-way compare outcome to skip count: greater none, equal one, less two.
  function automatic logic [1:0] cmpSkip(input logic gt, input logic eq);
    cmpSkip = gt ? 2'd0 : (eq ? 2'd1 : 2'd2);
  endfunction : cmpSkip

  // Word-aligned address decode, shared by the write enable and the error answer.
  function automatic logic isMapped(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    isMapped = (a == OFF_CMD) || (a == OFF_ACC) || (a == OFF_LONG) || (a == OFF_FAC) ||
               (a == OFF_GREG) || (a == OFF_HALF) || (a == OFF_MEM) ||
               (a == OFF_INDEX) || (a == OFF_FLAGS) || (a == OFF_PC) ||
               (a == OFF_STATUS);
  endfunction : isMapped

  // Byte-strobe merge of write data into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : merge

  // Which instruction groups exist in which addressing mode.
  function automatic logic modeLegal(input ctsu_op_t op, input ctsu_mode_t mode);
    case (op)
      OP_LOAD_HALF: modeLegal = (mode == MODE_I);
      OP_FSKIP: modeLegal = (mode == MODE_R) || (mode == MODE_V);
      OP_CMP_LONG: modeLegal = (mode == MODE_V);
      OP_LOAD_REG, OP_LOAD_CC, OP_LOAD_FAC, OP_LOAD_TRUE, OP_LOAD_FALSE: modeLegal = 1'b1;
      default: modeLegal = (mode != MODE_I);
    endcase
  endfunction : modeLegal

  // ==========================================================================
  // State.
  logic [15:0] acc;
  logic [31:0] longAcc;
  logic [31:0] fac;
  logic [31:0] greg;
  logic [31:0] halfSrc;
  logic [31:0] mem;
  logic [15:0] index;
  logic [3:0] flags;
  logic [15:0] pc;
  logic [3:0] status;
  ctsu_cmd_t cmdReg;
  logic [31:0] prdata;
  logic [15:0] next_acc;
  logic [31:0] next_longAcc;
  logic [31:0] next_fac;
  logic [31:0] next_greg;
  logic [31:0] next_halfSrc;
  logic [31:0] next_mem;
  logic [15:0] next_index;
  logic [3:0] next_flags;
  logic [15:0] next_pc;
  logic [3:0] next_status;
  ctsu_cmd_t next_cmdReg;
  logic [31:0] next_prdata;

  // ==========================================================================
  // APB decode; the slave always answers in the first access cycle.
  logic setupPh;
  logic accessPh;
  logic mapped;
  logic wrEn;
  logic [7:0] wordAddr;
  logic exec;
  logic run;
  logic fault;
  ctsu_cmd_t cmdNew;

  assign setupPh = apbReq.psel && !apbReq.penable;
  assign accessPh = apbReq.psel && apbReq.penable;
  assign mapped = isMapped(apbReq.paddr);
  assign wordAddr = {apbReq.paddr[7:2], 2'b00};
  assign wrEn = accessPh && apbReq.pwrite && mapped;
  assign cmdNew = ctsu_cmd_t'(apbReq.pwdata[CMD_W-1:0]);
  assign exec = wrEn && (wordAddr == OFF_CMD);
  assign run = exec && modeLegal(cmdNew.op, cmdNew.mode);
  assign fault = exec && !modeLegal(cmdNew.op, cmdNew.mode);

  // Handshake is combinational; read data comes from a flop filled in setup.
  assign apbRsp = '{prdata: prdata, pready: accessPh, pslverr: accessPh && !mapped};

  // ==========================================================================
  // Operand views. Integer sign is the top bit of each word.
  logic accNeg;
  logic accZero;
  logic longNeg;
  logic longZero;
  logic facNeg;
  logic facZero;
  logic [15:0] halfSel;
  logic [15:0] memInc;
  logic [15:0] idxDec;
  logic [15:0] idxInc;
  logic [3:0] bitPos;

  assign accNeg = acc[15];
  assign accZero = (acc == RST_W16);
  assign longNeg = longAcc[31];
  assign longZero = (longAcc == RST_W32);
  // A floating value is zero when all bits below the sign are clear, so minus zero is zero.
  assign facNeg = fac[31] && (fac[30:0] != 31'h0);
  assign facZero = (fac[30:0] == 31'h0);
  assign halfSel = cmdNew.bitSel[0] ? halfSrc[31:16] : halfSrc[15:0];
  assign memInc = 16'(mem[15:0] + ONE_W16);
  assign idxDec = 16'(index - ONE_W16);
  assign idxInc = 16'(index + ONE_W16);
  // Bits are numbered 1 to 16 from the top; field value n picks bit n+1.
  assign bitPos = 4'(4'hf - cmdNew.bitSel);

  // ==========================================================================
  // Next-state: register writes from the bus, then instruction execution.
  always_comb begin
    logic [1:0] skipCnt;
    logic [15:0] step;
    skipCnt = 2'd0;
    step = RST_W16;
    next_acc = acc;
    next_longAcc = longAcc;
    next_fac = fac;
    next_greg = greg;
    next_halfSrc = halfSrc;
    next_mem = mem;
    next_index = index;
    next_flags = flags;
    next_pc = pc;
    next_status = status;
    next_cmdReg = cmdReg;
    next_prdata = prdata;
    if (setupPh && !apbReq.pwrite) begin
      case ({apbReq.paddr[7:2], 2'b00})
        OFF_CMD: next_prdata = {17'h0, cmdReg};
        OFF_ACC: next_prdata = {16'h0, acc};
        OFF_LONG: next_prdata = longAcc;
        OFF_FAC: next_prdata = fac;
        OFF_GREG: next_prdata = greg;
        OFF_HALF: next_prdata = halfSrc;
        OFF_MEM: next_prdata = mem;
        OFF_INDEX: next_prdata = {16'h0, index};
        OFF_FLAGS: next_prdata = {28'h0, flags};
        OFF_PC: next_prdata = {16'h0, pc};
        OFF_STATUS: next_prdata = {28'h0, status};
        default: next_prdata = RST_W32;
      endcase
    end
    if (wrEn) begin
      case (wordAddr)
        OFF_ACC: next_acc = 16'(merge({16'h0, acc}, apbReq.pwdata, apbReq.pstrb));
        OFF_LONG: next_longAcc = merge(longAcc, apbReq.pwdata, apbReq.pstrb);
        OFF_FAC: next_fac = merge(fac, apbReq.pwdata, apbReq.pstrb);
        OFF_GREG: next_greg = merge(greg, apbReq.pwdata, apbReq.pstrb);
        OFF_HALF: next_halfSrc = merge(halfSrc, apbReq.pwdata, apbReq.pstrb);
        OFF_MEM: next_mem = merge(mem, apbReq.pwdata, apbReq.pstrb);
        OFF_INDEX: next_index = 16'(merge({16'h0, index}, apbReq.pwdata, apbReq.pstrb));
        OFF_FLAGS: next_flags = 4'(merge({28'h0, flags}, apbReq.pwdata, apbReq.pstrb));
        OFF_PC: next_pc = 16'(merge({16'h0, pc}, apbReq.pwdata, apbReq.pstrb));
        OFF_CMD: next_cmdReg = cmdNew;
        default: next_cmdReg = cmdReg;
      endcase
    end
    // An instruction not present in the chosen mode does nothing but flag a fault.
    if (fault) begin
      next_status = 4'(1 << ST_FAULT);
    end
    if (run) begin
      case (cmdNew.op)
        OP_LOAD_REG: next_acc = {15'h0, relTest(cmdNew.rel, accNeg, accZero)};
        OP_LOAD_CC: begin
          next_acc = {15'h0, relTest(cmdNew.rel, flags[FLAG_CCNEG], flags[FLAG_CCZERO])};
        end
        OP_LOAD_FAC: next_acc = {15'h0, relTest(cmdNew.rel, facNeg, facZero)};
        OP_LOAD_HALF: begin
          next_greg = {31'h0, relTest(cmdNew.rel, halfSel[15], halfSel == RST_W16)};
        end
        OP_LOAD_LONG: next_acc = {15'h0, relTest(cmdNew.rel, longNeg, longZero)};
        OP_LOAD_TRUE: next_acc = ONE_W16;
        OP_LOAD_FALSE: next_acc = RST_W16;
        OP_CMP_MEM: begin
          skipCnt = cmpSkip($signed(acc) > $signed(mem[15:0]), acc == mem[15:0]);
        end
        OP_CMP_ZERO: skipCnt = cmpSkip(!accNeg && !accZero, accZero);
        OP_CMP_LONG: begin
          skipCnt = cmpSkip($signed(longAcc) > $signed(mem), longAcc == mem);
        end
        OP_DEC_INDEX: begin
          next_index = idxDec;
          skipCnt = {1'b0, idxDec == RST_W16};
        end
        OP_INC_MEM: begin
          next_mem = {mem[31:16], memInc};
          skipCnt = {1'b0, memInc == RST_W16};
        end
        OP_INC_INDEX: begin
          next_index = idxInc;
          skipCnt = {1'b0, idxInc == RST_W16};
        end
        OP_SKIP_BIT_CLR: skipCnt = {1'b0, !acc[bitPos]};
        OP_SKIP_BIT_SET: skipCnt = {1'b0, acc[bitPos]};
        OP_SKIP_SIGN: skipCnt = {1'b0, relTest(cmdNew.rel, accNeg, accZero)};
        OP_SKIP_LOW0: skipCnt = {1'b0, !acc[0]};
        OP_SKIP_MC_CLR: skipCnt = {1'b0, !flags[FLAG_MCHK]};
        OP_SKIP_MC_SET: skipCnt = {1'b0, flags[FLAG_MCHK]};
        OP_SKIP_C_CLR: skipCnt = {1'b0, !flags[FLAG_CARRY]};
        OP_SKIP_C_SET: skipCnt = {1'b0, flags[FLAG_CARRY]};
        // The relation field selects greater, greater-or-equal, less-or-equal, minus, zero or non-zero.
        OP_FSKIP: skipCnt = {1'b0, relTest(cmdNew.rel, facNeg, facZero)};
        default: skipCnt = 2'd0;
      endcase
      // Normal sequencing steps over the instruction; a skip adds whole words on top.
      step = cmdNew.len2 ? TWO_W16 : ONE_W16;
      next_pc = 16'(pc + step + {14'h0, skipCnt});
      next_status = {skipCnt, 1'b0, skipCnt != 2'd0};
    end
  end

  // Register everything; reset clears all state.
  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= RST_W16;
      longAcc <= RST_W32;
      fac <= RST_W32;
      greg <= RST_W32;
      halfSrc <= RST_W32;
      mem <= RST_W32;
      index <= RST_W16;
      flags <= RST_W4;
      pc <= RST_W16;
      status <= RST_W4;
      cmdReg <= ctsu_cmd_t'(15'h0000);
      prdata <= RST_W32;
    end else begin
      acc <= next_acc;
      longAcc <= next_longAcc;
      fac <= next_fac;
      greg <= next_greg;
      halfSrc <= next_halfSrc;
      mem <= next_mem;
      index <= next_index;
      flags <= next_flags;
      pc <= next_pc;
      status <= next_status;
      cmdReg <= next_cmdReg;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Assertions and covers.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_reg_rel_load: assert property (
      run && cmdNew.op == OP_LOAD_REG && cmdNew.rel == REL_LT |=> acc == {15'h0, $past(accNeg)})
    else $error("register less-than load wrote the wrong value");

  a_cc_rel_load: assert property (
      run && cmdNew.op == OP_LOAD_CC && cmdNew.rel == REL_EQ
      |=> acc == {15'h0, $past(flags[FLAG_CCZERO])})
    else $error("condition-code equal load wrote the wrong value");

  a_fac_rel_load: assert property (
      run && cmdNew.op == OP_LOAD_FAC && cmdNew.rel == REL_GT
      |=> acc == {15'h0, !$past(facNeg) && !$past(facZero)})
    else $error("floating greater-than load wrote the wrong value");

  a_half_mode_only: assert property (
      exec && cmdNew.op == OP_LOAD_HALF && cmdNew.mode != MODE_I
      |=> $stable(greg) && status[ST_FAULT] && $stable(pc))
    else $error("half-register load acted outside its mode");

  a_long_rel_load: assert property (
      run && cmdNew.op == OP_LOAD_LONG && cmdNew.rel == REL_NE
      |=> acc == {15'h0, !$past(longZero)})
    else $error("long accumulator non-zero load wrote the wrong value");

  a_true_false: assert property (
      run && (cmdNew.op == OP_LOAD_TRUE || cmdNew.op == OP_LOAD_FALSE)
      |=> acc == (($past(cmdNew.op) == OP_LOAD_TRUE) ? ONE_W16 : RST_W16))
    else $error("load true or false wrote the wrong value");

  a_cmp_mem_eq: assert property (
      run && cmdNew.op == OP_CMP_MEM && acc == mem[15:0] |=> status[ST_CNT +: 2] == 2'd1)
    else $error("equal compare with memory did not skip one word");

  a_cmp_zero_neg: assert property (
      run && cmdNew.op == OP_CMP_ZERO && acc[15]
      |=> status[ST_CNT +: 2] == 2'd2 && status[ST_SKIP])
    else $error("negative accumulator compare did not skip two words");

  a_dec_index: assert property (
      run && cmdNew.op == OP_DEC_INDEX
      |=> index == 16'($past(index) - ONE_W16) && status[ST_SKIP] == (index == RST_W16))
    else $error("decrement index gave a wrong value or skip");

  a_inc_mem_wrap: assert property (
      run && cmdNew.op == OP_INC_MEM && mem[15:0] == 16'hffff
      |=> mem[15:0] == RST_W16 && status[ST_SKIP])
    else $error("increment memory wrap did not skip");

  a_skip_pc: assert property (
      run |=> pc == 16'($past(pc) + ($past(cmdNew.len2) ? TWO_W16 : ONE_W16)
          + {14'h0, status[ST_CNT +: 2]}))
    else $error("program counter did not advance by the instruction and skip");

  a_read_answer: assert property (setupPh && !apbReq.pwrite ##1 accessPh
      |-> apbRsp.pready)
    else $error("read access was not answered in its first access cycle");

  a_inc_index: assert property (
      run && cmdNew.op == OP_INC_INDEX
      |=> index == 16'($past(index) + ONE_W16) && status[ST_SKIP] == (index == RST_W16))
    else $error("increment index gave a wrong value or skip");

  // Bits count from the top, so field value zero must pick the sign bit.
  a_bit_clr_skip: assert property (
      run && cmdNew.op == OP_SKIP_BIT_CLR
      |=> status[ST_SKIP] == !$past(acc[4'(15 - cmdNew.bitSel)]))
    else $error("bit-clear skip tested the wrong accumulator bit");

  a_sign_gt_skip: assert property (
      run && cmdNew.op == OP_SKIP_SIGN && cmdNew.rel == REL_GT
      |=> status[ST_SKIP] == ($past($signed(acc)) > 16'sd0))
    else $error("greater-than sign skip decided wrongly");

  a_low_bit_skip: assert property (
      run && cmdNew.op == OP_SKIP_LOW0 |=> status[ST_SKIP] == !$past(acc[0]))
    else $error("low-bit skip decided wrongly");

  a_mchk_skip: assert property (
      run && cmdNew.op == OP_SKIP_MC_SET |=> status[ST_SKIP] == $past(flags[FLAG_MCHK]))
    else $error("machine-check set skip decided wrongly");

  a_carry_skip: assert property (
      run && cmdNew.op == OP_SKIP_C_CLR |=> status[ST_SKIP] == !$past(flags[FLAG_CARRY]))
    else $error("carry-clear skip decided wrongly");

  a_float_mode_only: assert property (
      exec && cmdNew.op == OP_FSKIP && (cmdNew.mode == MODE_S || cmdNew.mode == MODE_I)
      |=> status == 4'(1 << ST_FAULT) && $stable(pc))
    else $error("floating skip acted outside its modes");

  // Minus zero must still count as zero for the less-or-equal variant.
  a_float_le_skip: assert property (
      run && cmdNew.op == OP_FSKIP && cmdNew.rel == REL_LE
      |=> status[ST_SKIP] == $past(fac[31] || fac[30:0] == 31'h0))
    else $error("floating less-or-equal skip decided wrongly");

  c_skip_taken: cover property (run ##1 status[ST_SKIP]);
  c_cmp_two: cover property (run && cmdNew.op == OP_CMP_LONG ##1 status[ST_CNT +: 2] == 2'd2);
  c_mode_fault: cover property (fault ##1 status[ST_FAULT]);
  c_float_skip: cover property (run && cmdNew.op == OP_FSKIP ##1 status[ST_SKIP]);

endmodule : condition_test_skip_unit

// ### sim/condition_test_skip_unit_tb.sv
// Self-checking random testbench for the condition test and skip unit.
`timescale 1ns/1ps
module condition_test_skip_unit_tb;
  import ctsu_pkg::*;
  logic clk;
  logic srst;
  ctsu_apb_req_t apbReq;
  ctsu_apb_rsp_t apbRsp;
  int err_total;
  int tests_run;
  logic [15:0] mAcc, mIdx, mPc;
  logic [31:0] mLong, mFac, mGreg, mHalf, mMem, mSt;
  logic [3:0] mFlags;

  condition_test_skip_unit i_dut (
    .clk(clk),
    .srst(srst),
    .apbReq(apbReq),
    .apbRsp(apbRsp)
  );

  // 125 MHz clock.
  always #4 clk = ~clk;

  // ==========================================================================
  // Reporting
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // ==========================================================================
  // Register bus master
  // Every signal moves only right after a rising edge, so the slave never sees a race.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= addr;
    apbReq.pwdata <= wdata;
    apbReq.pstrb <= 4'hf;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    if (apbRsp.pready !== 1'b1) begin
      // A slave that never answers ends the run at once as a failure.
      check("pready", {31'h0, apbRsp.pready}, 32'h1);
      end_sim();
    end else begin
      rdata = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wdata, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input string name);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h0, rd, err);
    check(name, rd, exp);
    check("mapped read error", {31'h0, err}, 32'h0);
  endtask : rdchk

  // ==========================================================================
  // Reference model
  // Relation codes 6 and 7 never hold, so a stray code cannot look like a match.
  function automatic logic relOk(input logic signed [32:0] v, input logic [2:0] r);
    case (r)
      3'h0: return v == 0;
      3'h1: return v >= 0;
      3'h2: return v > 0;
      3'h3: return v <= 0;
      3'h4: return v < 0;
      3'h5: return v != 0;
      default: return 1'b0;
    endcase
  endfunction : relOk

  // Minus zero counts as zero, never as negative.
  function automatic logic signed [32:0] facVal(input logic [31:0] f);
    if (f[30:0] == 31'h0) return 33'sd0;
    return f[31] ? -33'sd1 : 33'sd1;
  endfunction : facVal

  function automatic logic [1:0] cmpCode(input logic signed [32:0] a, input logic signed [32:0] b);
    if (a > b) return 2'h0;
    return (a == b) ? 2'h1 : 2'h2;
  endfunction : cmpCode

  function automatic logic [15:0] pick();
    case ($urandom_range(7))
      0: return 16'h0000;
      1: return 16'h0001;
      2: return 16'hffff;
      3: return 16'h8000;
      4: return 16'h7fff;
      default: return 16'($urandom());
    endcase
  endfunction : pick

  task automatic predict(input ctsu_cmd_t c);
    logic [1:0] sc;
    logic legal;
    logic signed [32:0] cc;
    sc = 2'h0;
    cc = mFlags[3] ? 33'sd0 : (mFlags[2] ? -33'sd1 : 33'sd1);
    case (c.op)
      OP_LOAD_HALF: legal = (c.mode == MODE_I);
      OP_FSKIP: legal = (c.mode == MODE_R || c.mode == MODE_V);
      OP_CMP_LONG: legal = (c.mode == MODE_V);
      OP_LOAD_REG, OP_LOAD_CC, OP_LOAD_FAC, OP_LOAD_TRUE, OP_LOAD_FALSE: legal = 1'b1;
      default: legal = (c.mode != MODE_I);
    endcase
    if (!legal) begin
      mSt = 32'h2;
      return;
    end
    case (c.op)
      OP_LOAD_REG: mAcc = {15'h0, relOk($signed(mAcc), c.rel)};
      OP_LOAD_CC: mAcc = {15'h0, relOk(cc, c.rel)};
      OP_LOAD_FAC: mAcc = {15'h0, relOk(facVal(mFac), c.rel)};
      OP_LOAD_HALF: begin
        mGreg = {31'h0, relOk($signed(c.bitSel[0] ? mHalf[31:16] : mHalf[15:0]), c.rel)};
      end
      OP_LOAD_LONG: mAcc = {15'h0, relOk($signed(mLong), c.rel)};
      OP_LOAD_TRUE: mAcc = 16'h1;
      OP_LOAD_FALSE: mAcc = 16'h0;
      OP_CMP_MEM: sc = cmpCode($signed(mAcc), $signed(mMem[15:0]));
      OP_CMP_ZERO: sc = cmpCode($signed(mAcc), 33'sd0);
      OP_CMP_LONG: sc = cmpCode($signed(mLong), $signed(mMem));
      OP_DEC_INDEX: mIdx = mIdx - 16'h1;
      OP_INC_MEM: mMem[15:0] = mMem[15:0] + 16'h1;
      OP_INC_INDEX: mIdx = mIdx + 16'h1;
      OP_SKIP_BIT_CLR: sc = {1'b0, ~mAcc[4'hf - c.bitSel]};
      OP_SKIP_BIT_SET: sc = {1'b0, mAcc[4'hf - c.bitSel]};
      OP_SKIP_SIGN: sc = {1'b0, relOk($signed(mAcc), c.rel)};
      OP_SKIP_LOW0: sc = {1'b0, ~mAcc[0]};
      OP_SKIP_MC_CLR: sc = {1'b0, ~mFlags[1]};
      OP_SKIP_MC_SET: sc = {1'b0, mFlags[1]};
      OP_SKIP_C_CLR: sc = {1'b0, ~mFlags[0]};
      OP_SKIP_C_SET: sc = {1'b0, mFlags[0]};
      OP_FSKIP: sc = {1'b0, relOk(facVal(mFac), c.rel)};
      default: sc = 2'h0;
    endcase
    if (c.op == OP_DEC_INDEX || c.op == OP_INC_INDEX) sc = {1'b0, mIdx == 16'h0};
    if (c.op == OP_INC_MEM) sc = {1'b0, mMem[15:0] == 16'h0};
    mPc = mPc + (c.len2 ? 16'h2 : 16'h1) + {14'h0, sc};
    mSt = {28'h0, sc, 1'b0, sc != 2'h0};
  endtask : predict

  // ==========================================================================
  // Main sequence
  initial begin
    ctsu_cmd_t c;
    logic [31:0] rd;
    logic err;
    clk = 1'b0;
    srst = 1'b1;
    apbReq = '0;
    err_total = 0;
    tests_run = 0;
    mSt = 32'h0;
    void'($urandom(73));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Every register must read zero after reset.
    for (int a = 0; a <= 40; a += 4) begin
      rdchk(8'(a), 32'h0, "reset value");
    end
    // An unmapped word answers with an error and reads zero; status ignores writes.
    apb(1'b1, 8'h2c, 32'hffff_ffff, rd, err);
    check("unmapped write error", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h2c, 32'h0, rd, err);
    check("unmapped read error", {31'h0, err}, 32'h1);
    check("unmapped read data", rd, 32'h0);
    wr(OFF_STATUS, 32'hf);
    rdchk(OFF_STATUS, 32'h0, "status write");
    $display("test reset and map done, mismatches %0d", err_total);
    // Each operation meets each mode under every relation code, the two unused ones too.
    for (int i = 0; i < 704; i++) begin
      mAcc = pick();
      mIdx = pick();
      mPc = pick();
      mLong = {pick(), pick()};
      mFac = {pick(), pick()};
      mHalf = {pick(), pick()};
      mMem = {pick(), pick()};
      mGreg = {pick(), pick()};
      mFlags = 4'($urandom_range(15));
      mFlags[2] = mFlags[2] & ~mFlags[3];
      wr(OFF_ACC, {16'h0, mAcc});
      wr(OFF_INDEX, {16'h0, mIdx});
      wr(OFF_PC, {16'h0, mPc});
      wr(OFF_LONG, mLong);
      wr(OFF_FAC, mFac);
      wr(OFF_HALF, mHalf);
      wr(OFF_MEM, mMem);
      wr(OFF_GREG, mGreg);
      wr(OFF_FLAGS, {28'h0, mFlags});
      c = '0;
      c.op = ctsu_op_t'(i % 22);
      c.mode = ctsu_mode_t'((i / 22) % 4);
      c.rel = ctsu_rel_t'(3'(i / 88));
      c.bitSel = 4'($urandom_range(15));
      c.len2 = 1'($urandom_range(1));
      wr(OFF_CMD, {17'h0, c});
      predict(c);
      rdchk(OFF_ACC, {16'h0, mAcc}, "acc");
      rdchk(OFF_GREG, mGreg, "greg");
      rdchk(OFF_MEM, mMem, "mem");
      rdchk(OFF_INDEX, {16'h0, mIdx}, "index");
      rdchk(OFF_PC, {16'h0, mPc}, "pc");
      rdchk(OFF_STATUS, mSt, "status");
      rdchk(OFF_STATUS, mSt, "status again");
      if (i % 22 == 21) begin
        $display("test mode pass %0d done, mismatches %0d", i / 22, err_total);
      end
    end
    end_sim();
  end

endmodule : condition_test_skip_unit_tb
